// ==== logic/cpmc_pkg.sv ====
// Types and shared arithmetic of the CPU power-mode control.
// Assumes nothing beyond the register header.
package cpmc_pkg;

  // Power state of the core
  typedef enum logic [2:0] {
    CPMC_RUN,
    CPMC_IDLE,
    CPMC_SLEEP,
    CPMC_STAB,
    CPMC_OST
  } cpmc_state_t;

  // Last count of a reduced-rate period: code n gives 2^(n+1) cycles
  function automatic logic [7:0] cpmc_ratio_last(input logic [2:0] ratio);
    logic [8:0] span;
    span = 9'h002 << ratio;
    return 8'(span - 9'h001);
  endfunction

endpackage

// ==== logic/cpmc_rate_gate.sv ====
// Reduced-rate divider: one CPU execute strobe per selected period.
// Assumes enable and ratio come from registers on the same clock.
`timescale 1ns/1ns
module cpmc_rate_gate
  import cpmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control
  input wire logic enable_in,
  input wire logic [2:0] ratio_in,
  // Strobe
  output logic exec_out
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  // count modulo the period of 2^(ratio+1) cycles
  // Held at zero while disabled, so re-enabling restarts the period
  always_comb begin
    next_cnt = cnt;
    if (!enable_in) begin
      next_cnt = 8'h00;
    end else if (cnt >= cpmc_ratio_last(ratio_in)) begin
      next_cnt = 8'h00;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign exec_out = enable_in && (cnt == 8'h00);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  gate_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(enable_in) |-> exec_out)
    else $error("reduced rate did not restart on enable");

  gate_gap_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (exec_out && enable_in) ##1 enable_in |-> !exec_out)
    else $error("two execute strobes back to back");

endmodule

// ==== logic/cpmc_regs.svh ====
// Register map, field positions, reset values and timing of the CPU power-mode control.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef CPMC_REGS_SVH
`define CPMC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CPMC_REGULATOR_OFS 4'h0
`define CPMC_RATE_OFS 4'h4

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CPMC_LP_SELECT_BIT 1
`define CPMC_IDLE_BIT 7
`define CPMC_RATE_EN_BIT 6
`define CPMC_ROI_BIT 5
`define CPMC_DOE_BIT 4
`define CPMC_RATIO_MSB 2
`define CPMC_LP_SELECT_RST 1'b0
`define CPMC_RSVD_ONE 1'b1
`define CPMC_RATE_RST 8'h00
`define CPMC_ISR_VECTOR 16'h0004

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CPMC_CLK_NS 4
`define CPMC_OST_PERIODS 1024
`define CPMC_REG_STAB_NS 2000
`define CPMC_REG_STAB_CYC ((`CPMC_REG_STAB_NS + `CPMC_CLK_NS - 1) / `CPMC_CLK_NS)

`endif

// ==== logic/cpmc_top.sv ====
// CPU power-mode control: reduced rate, idle, sleep and wake sequencing.
// Assumes core and interrupt signals are on clk_in; registers on Avalon-MM.
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`include "cpmc_regs.svh"
module cpmc_top
  import cpmc_pkg::*;
#(
  parameter int DLY_W = 11
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // CPU core events
  input wire logic sleep_instr_in,
  input wire logic irq_entry_in,
  input wire logic return_from_irq_instr_in,
  input wire logic in_circuit_debug_in,
  // Interrupt logic and watchdog
  input wire logic irq_pending_in,
  input wire logic global_irq_enable_in,
  input wire logic watchdog_timer_timeout_in,
  // Oscillator mode
  input wire logic external_clock_mode_in,
  input wire logic internal_osc_mode_in,
  // Clock gating and regulator
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic regulator_low_power_out,
  output logic watchdog_timer_reset_block_out,
  // Sleep and wake reports
  output logic sleep_nop_out,
  output logic power_down_clear_out,
  output logic watchdog_timer_clear_out,
  output logic wake_resume_out,
  output logic wake_to_isr_out,
  output logic [15:0] isr_vector_out
);

  localparam logic [DLY_W-1:0] STAB_LAST = DLY_W'(`CPMC_REG_STAB_CYC - 1);
  localparam logic [DLY_W-1:0] OST_LAST = DLY_W'(`CPMC_OST_PERIODS - 1);
  localparam logic [DLY_W-1:0] DLY_ZERO = '0;
  localparam logic [DLY_W-1:0] DLY_ONE = DLY_W'(1);
  localparam logic [7:0] RATE_RST = `CPMC_RATE_RST;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic bus_req;
  logic wr_regulator;
  logic wr_rate;

  // Control fields
  logic lp_select;
  logic next_lp_select;
  logic idle_on_sleep_select;
  logic next_idle_on_sleep_select;
  logic reduced_rate_enable;
  logic next_reduced_rate_enable;
  logic recover_on_irq;
  logic next_recover_on_irq;
  logic reduce_on_return;
  logic next_reduce_on_return;
  logic [2:0] ratio;
  logic [2:0] next_ratio;
  logic [7:0] regulator_byte;
  logic [7:0] rate_byte;

  assign bus_req = avs_read_in || avs_write_in;
  // One wait state: every access is answered in the cycle after it arrives
  assign avs_waitrequest_out = bus_req && !ack;
  assign avs_readdata_out = rdata;
  assign wr_regulator = ack && avs_write_in && (avs_address_in == `CPMC_REGULATOR_OFS);
  assign wr_rate = ack && avs_write_in && (avs_address_in == `CPMC_RATE_OFS);

  assign regulator_byte = {6'h00, lp_select, `CPMC_RSVD_ONE};
  assign rate_byte = {idle_on_sleep_select, reduced_rate_enable, recover_on_irq,
                      reduce_on_return, 1'b0, ratio};

  // Read data is captured in the wait cycle and stands at the answer edge
  always_comb begin
    next_ack = bus_req && !ack;
    next_rdata = 32'h0000_0000;
    if (bus_req && !ack && avs_read_in) begin
      if (avs_address_in == `CPMC_REGULATOR_OFS) begin
        next_rdata = {24'h00_0000, regulator_byte};
      end else if (avs_address_in == `CPMC_RATE_OFS) begin
        next_rdata = {24'h00_0000, rate_byte};
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Hardware set of the reduced-rate enable is applied last, so it wins
  // over both a software write and an interrupt-entry clear
  always_comb begin
    next_lp_select = lp_select;
    next_idle_on_sleep_select = idle_on_sleep_select;
    next_reduced_rate_enable = reduced_rate_enable;
    next_recover_on_irq = recover_on_irq;
    next_reduce_on_return = reduce_on_return;
    next_ratio = ratio;
    if (wr_regulator) begin
      next_lp_select = avs_writedata_in[`CPMC_LP_SELECT_BIT];
    end
    if (wr_rate) begin
      next_idle_on_sleep_select = avs_writedata_in[`CPMC_IDLE_BIT];
      next_reduced_rate_enable = avs_writedata_in[`CPMC_RATE_EN_BIT];
      next_recover_on_irq = avs_writedata_in[`CPMC_ROI_BIT];
      next_reduce_on_return = avs_writedata_in[`CPMC_DOE_BIT];
      next_ratio = avs_writedata_in[`CPMC_RATIO_MSB:0];
    end
    if (irq_entry_in && recover_on_irq) begin
      next_reduced_rate_enable = 1'b0;
    end
    if (return_from_irq_instr_in && reduce_on_return) begin
      next_reduced_rate_enable = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lp_select <= `CPMC_LP_SELECT_RST;
      idle_on_sleep_select <= RATE_RST[`CPMC_IDLE_BIT];
      reduced_rate_enable <= RATE_RST[`CPMC_RATE_EN_BIT];
      recover_on_irq <= RATE_RST[`CPMC_ROI_BIT];
      reduce_on_return <= RATE_RST[`CPMC_DOE_BIT];
      ratio <= RATE_RST[`CPMC_RATIO_MSB:0];
    end else begin
      lp_select <= next_lp_select;
      idle_on_sleep_select <= next_idle_on_sleep_select;
      reduced_rate_enable <= next_reduced_rate_enable;
      recover_on_irq <= next_recover_on_irq;
      reduce_on_return <= next_reduce_on_return;
      ratio <= next_ratio;
    end
  end

  // ----------------------------------------------------------------
  // Power-state sequencer
  // ----------------------------------------------------------------
  cpmc_state_t state;
  cpmc_state_t next_state;
  logic [DLY_W-1:0] dly;
  logic [DLY_W-1:0] next_dly;
  logic by_irq;
  logic next_by_irq;
  logic crystal_mode;
  logic wake_event;
  logic done;
  logic done_irq;
  logic next_sleep_nop;
  logic next_pd_clear;
  logic next_wdt_clear;
  logic next_wake_resume;
  logic next_wake_isr;

  assign crystal_mode = !external_clock_mode_in && !internal_osc_mode_in;
  assign wake_event = irq_pending_in || watchdog_timer_timeout_in;

  always_comb begin
    next_state = state;
    next_dly = dly;
    next_by_irq = by_irq;
    done = 1'b0;
    done_irq = by_irq;
    next_sleep_nop = 1'b0;
    next_pd_clear = 1'b0;
    next_wdt_clear = 1'b0;
    next_wake_resume = 1'b0;
    next_wake_isr = 1'b0;
    case (state)
      CPMC_RUN: begin
        if (sleep_instr_in) begin
          if (irq_pending_in) begin
            next_sleep_nop = 1'b1;
          end else begin
            next_pd_clear = 1'b1;
            next_wdt_clear = 1'b1;
            next_state = idle_on_sleep_select ? CPMC_IDLE : CPMC_SLEEP;
          end
        end
      end
      CPMC_IDLE: begin
        // watchdog wakes idle
        // Oscillator never stopped, so idle resumes without delay
        if (wake_event) begin
          done = 1'b1;
          done_irq = irq_pending_in;
        end
      end
      CPMC_SLEEP: begin
        if (wake_event) begin
          next_by_irq = irq_pending_in;
          if (lp_select) begin
            next_state = CPMC_STAB;
            next_dly = STAB_LAST;
          end else if (crystal_mode) begin
            next_state = CPMC_OST;
            next_dly = OST_LAST;
          end else begin
            done = 1'b1;
            done_irq = irq_pending_in;
          end
        end
      end
      CPMC_STAB: begin
        if (dly == DLY_ZERO) begin
          if (crystal_mode) begin
            next_state = CPMC_OST;
            next_dly = OST_LAST;
          end else begin
            done = 1'b1;
          end
        end else begin
          next_dly = dly - DLY_ONE;
        end
      end
      CPMC_OST: begin
        if (dly == DLY_ZERO) begin
          done = 1'b1;
        end else begin
          next_dly = dly - DLY_ONE;
        end
      end
      default: begin
        next_state = CPMC_RUN;
      end
    endcase
    if (done) begin
      next_state = CPMC_RUN;
      next_by_irq = 1'b0;
      next_wdt_clear = 1'b1;
      next_wake_resume = 1'b1;
      next_wake_isr = done_irq && global_irq_enable_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= CPMC_RUN;
      dly <= '0;
      by_irq <= 1'b0;
      sleep_nop_out <= 1'b0;
      power_down_clear_out <= 1'b0;
      watchdog_timer_clear_out <= 1'b0;
      wake_resume_out <= 1'b0;
      wake_to_isr_out <= 1'b0;
      isr_vector_out <= `CPMC_ISR_VECTOR;
    end else begin
      state <= next_state;
      dly <= next_dly;
      by_irq <= next_by_irq;
      sleep_nop_out <= next_sleep_nop;
      power_down_clear_out <= next_pd_clear;
      watchdog_timer_clear_out <= next_wdt_clear;
      wake_resume_out <= next_wake_resume;
      wake_to_isr_out <= next_wake_isr;
      isr_vector_out <= `CPMC_ISR_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and regulator
  // ----------------------------------------------------------------
  logic exec_strobe;

  cpmc_rate_gate cpmc_rate_gate_inst (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .enable_in(reduced_rate_enable),
    .ratio_in(ratio),
    .exec_out(exec_strobe)
  );

  assign cpu_clk_en_out = (state == CPMC_RUN) &&
                          (in_circuit_debug_in || !reduced_rate_enable || exec_strobe);
  assign periph_clk_en_out = (state == CPMC_RUN) || (state == CPMC_IDLE);
  assign regulator_low_power_out = lp_select && (state == CPMC_SLEEP);
  assign watchdog_timer_reset_block_out = (state != CPMC_RUN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int OST_CYCLES = `CPMC_OST_PERIODS;
  logic [DLY_W:0] ost_seen;

  // Counts consecutive cycles spent in the start-up hold
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ost_seen <= '0;
    end else if (state == CPMC_OST) begin
      ost_seen <= ost_seen + (DLY_W + 1)'(1);
    end else begin
      ost_seen <= '0;
    end
  end

  ost_length_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(state == CPMC_OST) |-> (ost_seen == (DLY_W + 1)'(OST_CYCLES)))
    else $error("start-up hold length wrong");

  isr_vector_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == CPMC_IDLE && irq_pending_in && global_irq_enable_in)
    |=> wake_to_isr_out && wake_resume_out && isr_vector_out == `CPMC_ISR_VECTOR)
    else $error("interrupt wake did not vector");

  lp_regulator_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == CPMC_SLEEP) |-> (regulator_low_power_out == lp_select))
    else $error("regulator mode wrong in sleep");

  stab_delay_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == CPMC_SLEEP && wake_event && lp_select) |=> (state == CPMC_STAB)[*8])
    else $error("low-power wake skipped stabilisation");

  reserved_bits_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (avs_read_in && avs_waitrequest_out && avs_address_in == `CPMC_REGULATOR_OFS)
    |=> !avs_waitrequest_out && avs_readdata_out[0] && avs_readdata_out[7:2] == 6'h00)
    else $error("regulator reserved bits read wrong");

  idle_gating_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == CPMC_IDLE) |-> (!cpu_clk_en_out && periph_clk_en_out))
    else $error("idle gating wrong");

  recover_irq_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (irq_entry_in && recover_on_irq && !return_from_irq_instr_in) |=> !reduced_rate_enable)
    else $error("interrupt entry kept reduced rate");

  reduce_return_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (return_from_irq_instr_in && reduce_on_return) |=> reduced_rate_enable)
    else $error("return did not set reduced rate");

  debug_speed_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == CPMC_RUN && in_circuit_debug_in) |-> cpu_clk_en_out)
    else $error("debug did not force full speed");

  sleep_nop_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == CPMC_RUN && sleep_instr_in && irq_pending_in)
    |=> sleep_nop_out && state == CPMC_RUN && !watchdog_timer_clear_out && !power_down_clear_out)
    else $error("sleep with pending interrupt not a no-operation");

endmodule

// ==== tb/cpmc_core_model.sv ====
// Model of the CPU core and interrupt logic beside the power-mode control.
// Assumes the bench calls its tasks from one process, just after clk_in edges.
`timescale 1ns/1ns
module cpmc_core_model (
  // Clock
  input wire logic clk_in,
  // Core events
  output logic sleep_instr_out,
  output logic irq_entry_out,
  output logic return_out,
  // Interrupt logic and watchdog
  output logic irq_pending_out,
  output logic global_irq_enable_out,
  output logic watchdog_timer_timeout_out
);
  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  logic [3:0] ev = 4'h0;
  // Bit 0 sleep, 1 isr entry, 2 return, 3 watchdog time-out
  assign {watchdog_timer_timeout_out, return_out, irq_entry_out, sleep_instr_out} = ev;
  // Quiet core at time zero
  initial begin
    irq_pending_out = 1'b0;
    global_irq_enable_out = 1'b0;
  end
  // One-cycle event; returns at the edge that samples it
  task automatic pulse(input logic [3:0] v);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 4'h0;
  endtask
  // pending interrupt or watchdog time-out wakes
  // Interrupt flag stays up until software clears it, as a real source would
  task automatic wake(input logic by_wdt);
    if (by_wdt) begin
      pulse(4'h8);
    end else begin
      @(posedge clk_in);
      irq_pending_out <= 1'b1;
      @(posedge clk_in);
    end
  endtask
  // Software clears the flag
  task automatic clear();
    @(posedge clk_in);
    irq_pending_out <= 1'b0;
  endtask
  // Global enable changes only right after an edge
  task automatic set_gie(input logic v);
    global_irq_enable_out <= v;
  endtask
endmodule

// ==== tb/tb_cpmc_top.sv ====
// Self-checking bench of the CPU power-mode control.
// Assumes the core model drives core events; the bench drives bus and modes.
`timescale 1ns/1ns
`include "cpmc_regs.svh"
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_cpmc_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_in;
  logic resetn_in;
  logic [3:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic dbg;
  logic ext;
  logic ios;
  logic [31:0] rdat;
  logic wait_r;
  logic sl, ie, rt, pend, global_irq_enable, wdt;
  logic cpu_en, per_en, reg_lp, blk, nop, pdc, wdc, wres, wisr;
  logic [15:0] vec;
  logic [31:0] exp_rd;
  logic exp_w;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] lfsr = 32'd96014;
  logic [31:0] rq[$];
  logic wq[$];
  logic [4:0] tbl[7] = '{5'b10000, 5'b10001, 5'b10011, 5'b00001, 5'b00100, 5'b01011,
                         5'b01101};

  // Free-running system clock, 4 ns
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  cpmc_top cpmc_top_inst (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_r), .sleep_instr_in(sl), .irq_entry_in(ie),
    .return_from_irq_instr_in(rt), .in_circuit_debug_in(dbg), .irq_pending_in(pend),
    .global_irq_enable_in(global_irq_enable), .watchdog_timer_timeout_in(wdt),
    .external_clock_mode_in(ext), .internal_osc_mode_in(ios), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .regulator_low_power_out(reg_lp),
    .watchdog_timer_reset_block_out(blk), .sleep_nop_out(nop), .power_down_clear_out(pdc),
    .watchdog_timer_clear_out(wdc), .wake_resume_out(wres), .wake_to_isr_out(wisr),
    .isr_vector_out(vec));

  cpmc_core_model core_inst (.clk_in(clk_in), .sleep_instr_out(sl), .irq_entry_out(ie),
    .return_out(rt), .irq_pending_out(pend), .global_irq_enable_out(global_irq_enable),
    .watchdog_timer_timeout_out(wdt));

  // ----------------------------------------------------------------
  // Tasks and monitor
  // ----------------------------------------------------------------
  // Galois-free shift register; upper write bits carry it to the design
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One bus cycle; held until waitrequest is sampled low, reads noted for the monitor
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    int k;
    lfsr = nxt(lfsr);
    @(posedge clk_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {lfsr[23:0], d};
    if (!w) rq.push_back({24'h0, e});
    for (k = 0; k < 20; k++) begin
      @(posedge clk_in);
      if (wait_r === 1'b0) break;
    end
    if (k == 20) begin
      failures++;
      give_verdict();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Strobes seen over n edges
  task automatic cnt(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_in);
      c += (cpu_en === 1'b1);
    end
  endtask

  // Results are matched against the oldest note; a result with no note fails
  always @(posedge clk_in) begin
    if (rd === 1'b1 && wait_r === 1'b0) begin
      exp_rd = rq.size() > 0 ? rq.pop_front() : 'x;
      `CHK("readdata", exp_rd, rdat)
    end
    if (wres === 1'b1) begin
      exp_w = wq.size() > 0 ? wq.pop_front() : 1'bx;
      `CHK("wake_to_isr", exp_w, wisr)
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int c;
    int n;
    logic [4:0] cs;
    // Quiet bus and oscillator mode while reset is held
    resetn_in <= 1'b0;
    adr <= 4'h0;
    rd <= 1'b0;
    wr <= 1'b0;
    wdat <= 32'h0000_0000;
    dbg <= 1'b0;
    ext <= 1'b0;
    ios <= 1'b1;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus(0, `CPMC_REGULATOR_OFS, 0, 8'h01);
    bus(0, `CPMC_RATE_OFS, 0, `CPMC_RATE_RST);
    bus(1, `CPMC_REGULATOR_OFS, 8'hff, 0);
    bus(0, `CPMC_REGULATOR_OFS, 0, 8'h03);
    bus(1, 4'h8, 8'hff, 0);
    bus(0, 4'h8, 0, 8'h00);
    bus(1, `CPMC_REGULATOR_OFS, 8'h01, 0);
    $display("test registers done");
    // Four periods of any phase hold exactly four strobes
    for (int r = 0; r < 8; r++) begin
      bus(1, `CPMC_RATE_OFS, 8'h40 | 8'(r), 0);
      cnt(8 << r, c);
      `CHK("strobes", 4, c)
    end
    bus(1, `CPMC_RATE_OFS, 8'h07, 0);
    bus(1, `CPMC_RATE_OFS, 8'h47, 0);
    cnt(1, c);
    `CHK("first_strobe", 1, c)
    cnt(255, c);
    `CHK("idle_cycles", 0, c)
    @(posedge clk_in);
    dbg <= 1'b1;
    cnt(8, c);
    `CHK("debug_speed", 8, c)
    bus(0, `CPMC_RATE_OFS, 0, 8'h47);
    dbg <= 1'b0;
    bus(1, `CPMC_RATE_OFS, 8'h07, 0);
    cnt(8, c);
    `CHK("full_speed", 8, c)
    $display("test reduced rate done");
    // Hardware set and clear of the enable, then the same events with both off
    bus(1, `CPMC_RATE_OFS, 8'h71, 0);
    core_inst.pulse(4'h2);
    bus(0, `CPMC_RATE_OFS, 0, 8'h31);
    core_inst.pulse(4'h4);
    bus(0, `CPMC_RATE_OFS, 0, 8'h71);
    bus(1, `CPMC_RATE_OFS, 8'h41, 0);
    core_inst.pulse(4'h2);
    bus(0, `CPMC_RATE_OFS, 0, 8'h41);
    bus(1, `CPMC_RATE_OFS, 8'h01, 0);
    core_inst.pulse(4'h4);
    bus(0, `CPMC_RATE_OFS, 0, 8'h01);
    $display("test interrupt entry and return done");
    // Table bits: idle, low power, crystal, watchdog wake, global enable
    foreach (tbl[i]) begin
      cs = tbl[i];
      lfsr = nxt(lfsr);
      @(posedge clk_in);
      ext <= !cs[2] & lfsr[0];
      ios <= !cs[2] & !lfsr[0];
      core_inst.set_gie(cs[0]);
      bus(1, `CPMC_REGULATOR_OFS, {6'h0, cs[3], 1'b1}, 0);
      bus(1, `CPMC_RATE_OFS, {cs[4], 7'h60}, 0);
      core_inst.pulse(4'h1);
      @(posedge clk_in);
      `CHK("pd_clear", 1'b1, pdc)
      `CHK("periph_en", cs[4], per_en)
      `CHK("cpu_en", 1'b0, cpu_en)
      `CHK("reg_lp", cs[3] & !cs[4], reg_lp)
      `CHK("wdt_block", 1'b1, blk)
      wq.push_back(!cs[1] & cs[0]);
      core_inst.wake(cs[1]);
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (wres !== 1'b1 && n < 3000);
      `CHK("latency", 1 + `CPMC_REG_STAB_CYC * cs[3] + `CPMC_OST_PERIODS * cs[2], n)
      // A wake that never completed ends the run here
      if (wres !== 1'b1) give_verdict();
      `CHK("vector", `CPMC_ISR_VECTOR, vec)
      `CHK("wake_wdt_clear", 1'b1, wdc)
      if (!cs[1] & cs[0]) core_inst.pulse(4'h2);
      core_inst.clear();
      bus(0, `CPMC_RATE_OFS, 0, {cs[4], !(!cs[1] & cs[0]), 6'h20});
      $display("test sleep case %0d done", i);
    end
    // Pending interrupt turns sleep into a no-operation
    core_inst.wake(1'b0);
    core_inst.pulse(4'h1);
    @(posedge clk_in);
    `CHK("sleep_nop", 1'b1, nop)
    `CHK("nop_pd_clear", 1'b0, pdc)
    `CHK("nop_wdt_clear", 1'b0, wdc)
    core_inst.clear();
    $display("test sleep nop done");
    give_verdict();
  end
endmodule
